// file: shared/wel_protect_defines.vh
// Opcodes, counts and field positions for the write-enable and sector
// protection command logic.
// Included by the command interpreter design file only; holds definitions only.
`ifndef WEL_PROTECT_DEFINES_VH
`define WEL_PROTECT_DEFINES_VH
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PROTECT_SECTOR 8'h36
`define OP_UNPROTECT_SECTOR 8'h39
`define OP_WRITE_STATUS1 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define SECTOR_LSB 16
`define SECTOR_BITS 2
`define NUM_SECTORS 4
`define STATUS_LOCK_BIT 7
`define STATUS_GLOBAL_HI 5
`define STATUS_GLOBAL_LO 2
`define BYTES_ADDR_DONE 3'h4
`endif

// file: src/spi_byte_shifter.v
// Serial byte shifter: samples serial data on rising serial-clock edges
// while chip select is low, and reports each completed byte.
// Assumes edge strobes come from already synchronised pin samples.
`timescale 1ns/10ps
`default_nettype none
module spi_byte_shifter
(
  input wire clock,
  input wire rst,
  input wire enable,
  input wire frame_active,
  input wire sclk_rise,
  input wire mosi_bit,
  output reg [7:0] byte_data_reg,
  output reg byte_done_reg,
  output reg [2:0] bit_count_reg
);
  reg [6:0] shift_reg;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      shift_reg <= 7'h00;
      byte_data_reg <= 8'h00;
      byte_done_reg <= 1'b0;
      bit_count_reg <= 3'h0;
    end
    else if (enable)
    begin
      byte_done_reg <= 1'b0;
      if (!frame_active)
        bit_count_reg <= 3'h0;
      else if (sclk_rise)
      begin
        shift_reg <= {shift_reg[5:0], mosi_bit};
        bit_count_reg <= bit_count_reg + 3'h1;
        if (bit_count_reg == 3'h7)
        begin
          byte_data_reg <= {shift_reg, mosi_bit};
          byte_done_reg <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: src/wel_protect_ctrl.v
// Write-enable latch and sector protection command interpreter of a serial
// flash. Runs on a fast system clock that oversamples the serial pins.
// Assumes serial clock, chip select and data arrive asynchronously.
// What this block does
// - Write-enable opcode 06h sets the latch when chip select rises.
// - Program, erase, protect, unprotect, status write need latch already set.
// - Enable and disable abort on partial byte; latch then stays unchanged.
// - Write-disable opcode 04h clears the latch when chip select rises.
// - Bytes after the enable or disable opcode are ignored.
// - Each 64-Kbyte sector has one flag, all set at power-up.
// - Unprotected sectors accept program and erase; protected ones reject.
// - Opcode 36h plus three address bytes protects sector, clears latch.
// - Opcode 39h plus three address bytes unprotects sector, clears latch.
// - Any address in a sector selects it; extra bytes are ignored.
// - Short address or partial byte: flag unchanged, latch cleared.
// - Lock bit set: protect and unprotect ignored, latch cleared.
// - Status write of ones to bits 5..2 protects every sector.
// - Status write of zeros to bits 5..2 unprotects every sector.
// - Status write also updates the protection lock bit.
// - Write-protect pin low with lock set freezes flags and lock.
// - Program or erase on protected sector is refused, latch cleared.
`timescale 1ns/10ps
`default_nettype none
`include "wel_protect_defines.vh"
module wel_protect_ctrl
#(
  parameter NUM_SECTORS = `NUM_SECTORS
)
(
  input wire clock,
  input wire rst,
  input wire clock_enable,
  input wire sclk_pin,
  input wire cs_n_pin,
  input wire mosi_pin,
  input wire write_protect_n_pin,
  output reg write_enable_latch,
  output reg protection_regs_locked,
  output reg [NUM_SECTORS-1:0] sector_protect,
  output reg program_start,
  output reg erase_start,
  output reg [23:0] op_address,
  output reg [7:0] op_code
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_SKIP = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage feeds only the second stage.
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] wp_sync_reg;
  reg sclk_last_reg;
  reg cs_last_reg;
  wire sclk_rise;
  wire frame_active;
  wire frame_end;
  wire [7:0] rx_byte;
  wire rx_done;
  wire [2:0] bit_count;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclk_sync_reg <= 2'b00;
      cs_sync_reg <= 2'b11;
      mosi_sync_reg <= 2'b00;
      wp_sync_reg <= 2'b11;
      sclk_last_reg <= 1'b0;
      cs_last_reg <= 1'b1;
    end
    else if (clock_enable)
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
      wp_sync_reg <= {wp_sync_reg[0], write_protect_n_pin};
      sclk_last_reg <= sclk_sync_reg[1];
      cs_last_reg <= cs_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg & ~cs_sync_reg[1];
  assign frame_active = ~cs_sync_reg[1];
  assign frame_end = cs_sync_reg[1] & ~cs_last_reg;

  spi_byte_shifter shifter
  (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .frame_active(frame_active),
    .sclk_rise(sclk_rise),
    .mosi_bit(mosi_sync_reg[1]),
    .byte_data_reg(rx_byte),
    .byte_done_reg(rx_done),
    .bit_count_reg(bit_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decoding. A frame's result is applied only when chip select
  // rises, so a host may abandon a command up to the last moment.
  reg [3:0] state_reg;
  reg [7:0] opcode_reg;
  reg [2:0] byte_count_reg;
  reg [23:0] addr_reg;
  reg [7:0] status_data_reg;
  reg wel_at_start_reg;
  reg sector_sel_prot;
  wire byte_aligned;
  wire addr_done;
  wire is_erase;
  wire is_chip_erase;
  wire is_program;
  wire hard_locked;
  wire [`SECTOR_BITS-1:0] sector_index;
  wire [3:0] global_bits;

  assign byte_aligned = (bit_count == 3'h0);
  assign addr_done = (byte_count_reg >= `BYTES_ADDR_DONE);
  assign sector_index = addr_reg[`SECTOR_LSB+`SECTOR_BITS-1:`SECTOR_LSB];
  assign is_program = (opcode_reg == `OP_PAGE_PROGRAM);
  assign is_chip_erase = (opcode_reg == `OP_CHIP_ERASE_A) | (opcode_reg == `OP_CHIP_ERASE_B);
  assign is_erase = (opcode_reg == `OP_ERASE_4K) | (opcode_reg == `OP_ERASE_32K) |
    (opcode_reg == `OP_ERASE_64K);
  assign hard_locked = ~wp_sync_reg[1] & protection_regs_locked;
  assign global_bits = status_data_reg[`STATUS_GLOBAL_HI:`STATUS_GLOBAL_LO];

  always @*
  begin
    sector_sel_prot = sector_protect[sector_index];
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      opcode_reg <= 8'h00;
      byte_count_reg <= 3'h0;
      addr_reg <= 24'h00_0000;
      status_data_reg <= 8'h00;
      wel_at_start_reg <= 1'b0;
      write_enable_latch <= 1'b0;
      protection_regs_locked <= 1'b0;
      sector_protect <= {NUM_SECTORS{1'b1}};
      program_start <= 1'b0;
      erase_start <= 1'b0;
      op_address <= 24'h00_0000;
      op_code <= 8'h00;
    end
    else if (clock_enable)
    begin
      program_start <= 1'b0;
      erase_start <= 1'b0;
      if (frame_end)
      begin
        state_reg <= ST_IDLE;
        byte_count_reg <= 3'h0;
        case (opcode_reg)
          `OP_WRITE_ENABLE:
            if (byte_count_reg != 3'h0 && byte_aligned)
              write_enable_latch <= 1'b1;
          `OP_WRITE_DISABLE:
            if (byte_count_reg != 3'h0 && byte_aligned)
              write_enable_latch <= 1'b0;
          `OP_PROTECT_SECTOR, `OP_UNPROTECT_SECTOR:
          begin
            write_enable_latch <= 1'b0;
            if (wel_at_start_reg && addr_done && byte_aligned && !protection_regs_locked)
              sector_protect[sector_index] <= (opcode_reg == `OP_PROTECT_SECTOR);
          end
          `OP_WRITE_STATUS1:
          begin
            if (wel_at_start_reg && byte_count_reg >= 3'h2 && byte_aligned)
            begin
              write_enable_latch <= 1'b0;
              if (!hard_locked)
              begin
                protection_regs_locked <= status_data_reg[`STATUS_LOCK_BIT];
                if (global_bits == 4'hF)
                  sector_protect <= {NUM_SECTORS{1'b1}};
                else if (global_bits == 4'h0)
                  sector_protect <= {NUM_SECTORS{1'b0}};
              end
            end
          end
          default:
          begin
            if (wel_at_start_reg && (is_program || is_erase || is_chip_erase))
            begin
              // Refused or accepted, the latch drops; the array engine ends later.
              write_enable_latch <= 1'b0;
              if (byte_aligned && is_chip_erase && sector_protect == {NUM_SECTORS{1'b0}})
                erase_start <= 1'b1;
              else if (byte_aligned && addr_done && !sector_sel_prot)
              begin
                erase_start <= is_erase;
                program_start <= is_program && byte_count_reg > `BYTES_ADDR_DONE;
              end
              op_address <= addr_reg;
              op_code <= opcode_reg;
            end
          end
        endcase
        opcode_reg <= 8'h00;
      end
      else if (frame_active && rx_done)
      begin
        if (byte_count_reg != 3'h7)
          byte_count_reg <= byte_count_reg + 3'h1;
        case (state_reg)
          ST_IDLE:
          begin
            opcode_reg <= rx_byte;
            wel_at_start_reg <= write_enable_latch;
            if (rx_byte == `OP_WRITE_STATUS1)
              state_reg <= ST_DATA;
            else if (rx_byte == `OP_WRITE_ENABLE || rx_byte == `OP_WRITE_DISABLE ||
              rx_byte == `OP_CHIP_ERASE_A || rx_byte == `OP_CHIP_ERASE_B)
              state_reg <= ST_SKIP;
            else
              state_reg <= ST_ADDR;
          end
          ST_ADDR:
          begin
            addr_reg <= {addr_reg[15:0], rx_byte};
            if (byte_count_reg == 3'h3)
              state_reg <= ST_SKIP;
          end
          ST_DATA:
          begin
            status_data_reg <= rx_byte;
            state_reg <= ST_SKIP;
          end
          ST_SKIP:
            state_reg <= ST_SKIP;
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/wel_protect_sva.sv
// Checker for the write-enable and sector protection logic.
// Assumes only the ports of wel_protect_ctrl; bound below.
`timescale 1ns/10ps
`default_nettype none
module wel_protect_sva
#(
  parameter NUM_SECTORS = 4
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic write_protect_n_pin,
  input wire logic write_enable_latch,
  input wire logic protection_regs_locked,
  input wire logic [NUM_SECTORS-1:0] sector_protect,
  input wire logic program_start,
  input wire logic erase_start,
  input wire logic [23:0] op_address
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence frame_over;
    cs_n_pin && $past(cs_n_pin, 2);
  endsequence
  // Pin sampling lags, so only a lock held four cycles is trusted.
  sequence hard_locked;
    (!write_protect_n_pin && protection_regs_locked) [*4];
  endsequence
  a_reset_state: assert property (
    $fell(rst) |-> &sector_protect && !write_enable_latch) else $error("bad reset state");
  a_flags_at_end: assert property (
    !$stable(sector_protect) |-> frame_over) else $error("flags moved inside frame");
  a_latch_at_end: assert property (
    !$stable(write_enable_latch) |-> frame_over) else $error("latch moved inside frame");
  a_flags_clear_latch: assert property (
    !$stable(sector_protect) |-> !write_enable_latch) else $error("latch kept");
  a_lock_frozen: assert property (
    hard_locked |=> protection_regs_locked && $stable(sector_protect)) else $error("lock ignored");
  a_program_unprot: assert property (
    program_start |-> !sector_protect[op_address[17:16]]) else $error("program on protected");
  a_program_pulse: assert property (
    program_start |=> !program_start && cs_n_pin) else $error("program pulse too long");
  a_erase_pulse: assert property (
    erase_start |=> !erase_start && cs_n_pin) else $error("erase pulse too long");
endmodule
bind wel_protect_ctrl wel_protect_sva #(.NUM_SECTORS(NUM_SECTORS)) wel_protect_sva_i
  (.clock(clock), .rst(rst), .cs_n_pin(cs_n_pin), .write_protect_n_pin(write_protect_n_pin),
  .write_enable_latch(write_enable_latch), .protection_regs_locked(protection_regs_locked),
  .sector_protect(sector_protect), .program_start(program_start),
  .erase_start(erase_start), .op_address(op_address));
`default_nettype wire

// file: verif/spi_host.sv
// Serial host model: mode 0 frames, MSB first, 400 ns serial clock.
// Assumes the 50 ns system clock; the serial clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module spi_host
(
  input wire logic clock,
  output var logic sclk_pin,
  output var logic cs_n_pin,
  output var logic mosi_pin
);
  initial
  begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    mosi_pin = 1'b0;
  end
  task automatic frame(input logic [63:0] d, input int n);
    @(posedge clock);
    cs_n_pin <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      mosi_pin <= d[63-i];
      repeat (4) @(posedge clock);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clock);
      sclk_pin <= 1'b0;
    end
    repeat (4) @(posedge clock);
    cs_n_pin <= 1'b1;
    mosi_pin <= ~mosi_pin;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the write-enable and sector protection logic.
// Assumes the host model drives the serial pins of the design.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, rst, clock_enable, write_protect_n_pin, sclk_pin, cs_n_pin, mosi_pin;
  logic write_enable_latch, protection_regs_locked, program_start, erase_start, go_seen;
  logic [3:0] sector_protect, sp;
  logic [23:0] op_address;
  logic [7:0] op_code;
  logic wel, lock, go;
  logic [7:0] exp_q[$];
  logic [31:0] r;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  wel_protect_ctrl wel_protect_ctrl_i (.clock(clock), .rst(rst), .clock_enable(clock_enable),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin),
    .write_protect_n_pin(write_protect_n_pin), .write_enable_latch(write_enable_latch),
    .protection_regs_locked(protection_regs_locked), .sector_protect(sector_protect),
    .program_start(program_start), .erase_start(erase_start), .op_address(op_address),
    .op_code(op_code));
  spi_host spi_host_i (.clock(clock), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin));
  always #25 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task run(input logic [63:0] d, input int n);
    exp_q.push_back({1'b0, wel, lock, sp, go});
    spi_host_i.frame(d, n);
    go = 1'b0;
  endtask
  task wren;
    wel = 1'b1;
    run({8'h06, 56'h0}, 8);
    wel = 1'b0;
  endtask
  task st(input logic [7:0] v, input logic [3:0] e, input logic l);
    wren;
    sp = e;
    lock = l;
    run({8'h01, v, 48'h0}, 16);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Results settle 3 to 4 cycles after chip select rises; six cycles leave margin.
  always @(posedge cs_n_pin)
  begin
    if (exp_q.size() > 0)
    begin
      go_seen = 1'b0;
      repeat (6)
      begin
        @(negedge clock);
        go_seen = go_seen | program_start | erase_start;
      end
      check({1'b0, write_enable_latch, protection_regs_locked, sector_protect, go_seen},
        exp_q.pop_front());
    end
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_fail++;
      conclude;
    end
  end
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    clock_enable = 1'b1;
    write_protect_n_pin = 1'b1;
    wel = 1'b0;
    lock = 1'b0;
    go = 1'b0;
    sp = 4'hF;
    r = $urandom(32'hb245);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1;
    check({1'b0, write_enable_latch, protection_regs_locked, sector_protect, 1'b0},
      {3'h0, sp, 1'b0});
    @(posedge clock);
    clock_enable <= 1'b0;
    run({8'h06, 56'h0}, 8);
    clock_enable <= 1'b1;
    run({8'h06, 56'h0}, 7);
    r = $urandom;
    wel = 1'b1;
    run({8'h06, r[7:0], 48'h0}, 16);
    wel = 1'b0;
    run({8'h04, 56'h0}, 8);
    run({8'h39, 56'h0}, 32);
    for (int k = 0; k < 4; k++)
    begin
      wren;
      r = $urandom;
      sp[k] = 1'b0;
      run({8'h39, 6'h00, k[1:0], r[15:0], r[23:16], 24'h0}, 40);
    end
    wren;
    run({8'h36, 16'h0002, 40'h0}, 24);
    wren;
    sp[2] = 1'b1;
    run({8'h36, 24'h020000, 32'h0}, 32);
    wren;
    run({8'h02, 24'h020000, 8'hA5, 24'h0}, 40);
    wren;
    go = 1'b1;
    run({8'h02, 24'h010000, 8'hA5, 24'h0}, 40);
    check(op_code, 8'h02);
    check(op_address[23:16], 8'h01);
    wren;
    run({8'hD8, 24'h020000, 32'h0}, 32);
    check(op_code, 8'hD8);
    st(8'h00, 4'h0, 1'b0);
    wren;
    go = 1'b1;
    run({8'h20, 24'h03_0000, 32'h0}, 32);
    wren;
    go = 1'b1;
    run({8'h52, 24'h00_8000, 32'h0}, 32);
    wren;
    go = 1'b1;
    run({8'hC7, 56'h0}, 8);
    st(8'h3C, 4'hF, 1'b0);
    wren;
    run({8'h60, 56'h0}, 8);
    st(8'h14, 4'hF, 1'b0);
    st(8'h80, 4'h0, 1'b1);
    wren;
    run({8'h36, 24'h010000, 32'h0}, 32);
    @(posedge clock);
    write_protect_n_pin <= 1'b0;
    st(8'h3C, 4'h0, 1'b1);
    @(posedge clock);
    write_protect_n_pin <= 1'b1;
    st(8'h3C, 4'hF, 1'b0);
    repeat (10) @(posedge clock);
    conclude;
  end
endmodule
`default_nettype wire
